// file: core/pumd_decoder.sv
// PCI target: upper configuration header and 4K memory window decode for eight UART channels
`timescale 1ns/1ps
`default_nettype none
module pumd_decoder #(
	parameter int TX_BUF_DEPTH = pumd_pkg::TX_DEPTH
) (
	input wire logic I_CLOCK,
	input wire logic I_RESET_N,
	input wire logic I_FRAME_N,
	input wire logic I_IRDY_N,
	input wire logic I_IDSEL,
	input wire logic [3:0] I_CBE_N,
	input wire logic [31:0] I_AD,
	output logic [31:0] O_AD,
	output logic O_AD_OE_N,
	output logic O_TRDY_N,
	output logic O_DEVSEL_N,
	output logic O_STOP_N,
	output logic O_CTL_OE_N,
	input wire logic I_EE_LOAD,
	input wire logic [31:0] I_EE_SUBSYS,
	output logic O_REG_REQ,
	output logic O_REG_WR,
	output logic O_REG_DEVCFG,
	output logic [pumd_pkg::CH_W-1:0] O_REG_CH,
	output logic [8:0] O_REG_OFFSET,
	output logic [3:0] O_REG_BE,
	output logic [31:0] O_REG_WDATA,
	input wire logic [31:0] I_REG_RDATA,
	output logic O_RX_POP,
	output logic [pumd_pkg::CH_W-1:0] O_RX_CH,
	output logic [2:0] O_RX_COUNT,
	input wire logic [31:0] I_RX_DATA,
	input wire logic [31:0] I_RX_STATUS,
	output logic O_TX_VALID,
	input wire logic I_TX_READY,
	output logic [pumd_pkg::CH_W-1:0] O_TX_CH,
	output logic [2:0] O_TX_COUNT,
	output logic [31:0] O_TX_DATA
);
	import pumd_pkg::*;

	typedef enum logic [5:0] {
		ST_IDLE = 6'b000001,
		ST_WAIT_IRDY = 6'b000010,
		ST_EXEC = 6'b000100,
		ST_RDATA = 6'b001000,
		ST_XFER = 6'b010000,
		ST_TURN = 6'b100000
	} pumd_state_e;

	function automatic logic [2:0] lane_count(input logic [3:0] be);
		lane_count = 3'(be[0]) + 3'(be[1]) + 3'(be[2]) + 3'(be[3]);
	endfunction

	function automatic logic [4:0] lane_shift(input logic [3:0] be);
		if (be[0]) begin
			lane_shift = 5'd0;
		end else if (be[1]) begin
			lane_shift = 5'd8;
		end else if (be[2]) begin
			lane_shift = 5'd16;
		end else begin
			lane_shift = 5'd24;
		end
	endfunction

	// Pins come from the bus, so they are retimed before any decode
	logic [PIN_W-1:0] pin_meta_q;
	logic [PIN_W-1:0] pin_q;
	logic frame_n_s;
	logic irdy_n_s;
	logic idsel_s;
	logic [3:0] cbe_n_s;
	logic [31:0] ad_s;
	logic frame_prev_q;

	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			pin_meta_q <= PIN_RST;
			pin_q <= PIN_RST;
			frame_prev_q <= 1'b1;
		end else begin
			pin_meta_q <= {I_FRAME_N, I_IRDY_N, I_IDSEL, I_CBE_N, I_AD};
			pin_q <= pin_meta_q;
			frame_prev_q <= frame_n_s;
		end
	end
	assign {frame_n_s, irdy_n_s, idsel_s, cbe_n_s, ad_s} = pin_q;

	pumd_state_e state_q;
	pumd_state_e state_d;
	logic is_cfg_q;
	logic is_wr_q;
	logic [11:2] addr_q;
	logic [3:0] be_q;
	logic [31:0] wdata_q;
	logic [31:0] rdata_d;
	logic mem_en_q;
	logic [BASE_W-1:0] base_q;
	logic [31:0] subsys_q;
	logic [7:0] int_line_q;

	logic frame_start;
	logic cfg_hit;
	logic mem_hit;
	logic [CH_W-1:0] blk_ch;
	logic [6:0] blk_dw;
	logic rg_uart;
	logic rg_devcfg;
	logic rg_fifo;
	logic rg_stat;
	logic stat_ok;
	logic tx_ready;
	logic tx_push;
	logic [31:0] cfg_rd;
	logic [31:0] rx_lanes;
	logic [31:0] stat_word;

	assign frame_start = frame_prev_q && !frame_n_s;
	assign cfg_hit = idsel_s && (cbe_n_s == CMD_CFG_RD || cbe_n_s == CMD_CFG_WR) && (ad_s[1:0] == 2'b00);
	assign mem_hit = mem_en_q && (cbe_n_s == CMD_MEM_RD || cbe_n_s == CMD_MEM_WR)
		&& (ad_s[31:BASE_LSB] == base_q);

	assign blk_ch = addr_q[11:9];
	assign blk_dw = addr_q[8:2];
	assign rg_uart = (blk_dw[6:2] == DW_UART_TAG);
	assign rg_devcfg = (blk_ch == '0) && (blk_dw >= DW_DEVCFG_LO) && (blk_dw <= DW_DEVCFG_HI);
	assign rg_fifo = (blk_dw[6:4] == DW_FIFO_TAG);
	assign rg_stat = (blk_dw[6:5] == DW_STAT_TAG);
	// only 16 or 32 bit lanes
	assign stat_ok = (be_q == 4'b0011) || (be_q == 4'b1100) || (be_q == 4'b1111);

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_IDLE: begin
				if (frame_start && (cfg_hit || mem_hit)) begin
					state_d = ST_WAIT_IRDY;
				end
			end
			ST_WAIT_IRDY: begin
				if (!irdy_n_s) begin
					state_d = ST_EXEC;
				end
			end
			ST_EXEC: begin
				if (!is_cfg_q && !is_wr_q && (rg_uart || rg_devcfg)) begin
					state_d = ST_RDATA;
				end else if (!is_cfg_q && is_wr_q && rg_fifo && !tx_ready) begin
					state_d = ST_EXEC;
				end else begin
					state_d = ST_XFER;
				end
			end
			ST_RDATA: state_d = ST_XFER;
			ST_XFER: state_d = ST_TURN;
			ST_TURN: begin
				if (frame_n_s && irdy_n_s) begin
					state_d = ST_IDLE;
				end
			end
			default: state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			state_q <= ST_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// Address and data phase capture
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			is_cfg_q <= 1'b0;
			is_wr_q <= 1'b0;
			addr_q <= '0;
			be_q <= 4'h0;
			wdata_q <= 32'h0000_0000;
		end else begin
			if (state_q == ST_IDLE && frame_start) begin
				is_cfg_q <= cfg_hit;
				is_wr_q <= cbe_n_s[0];
				addr_q <= ad_s[11:2];
			end
			if (state_q == ST_WAIT_IRDY && !irdy_n_s) begin
				be_q <= ~cbe_n_s;
				wdata_q <= ad_s;
			end
		end
	end

	// Configuration registers written by the host
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			mem_en_q <= 1'b0;
			base_q <= BASE_RST;
			int_line_q <= INT_LINE_RST;
		end else if (state_q == ST_EXEC && is_cfg_q && is_wr_q) begin
			if ({addr_q[7:2], 2'b00} == CFG_COMMAND && be_q[0]) begin
				mem_en_q <= wdata_q[CMD_MEM_EN_BIT];
			end
			if ({addr_q[7:2], 2'b00} == CFG_MEM_BASE) begin
				if (be_q[3]) begin
					base_q[19:12] <= wdata_q[31:24];
				end
				if (be_q[2]) begin
					base_q[11:4] <= wdata_q[23:16];
				end
				if (be_q[1]) begin
					base_q[3:0] <= wdata_q[15:12];
				end
			end
			if ({addr_q[7:2], 2'b00} == CFG_INT_ROUTE && be_q[0]) begin
				int_line_q <= wdata_q[7:0];
			end
		end
	end

	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			subsys_q <= SUBSYS_RST;
		end else if (I_EE_LOAD) begin
			subsys_q <= I_EE_SUBSYS;
		end
	end

	always_comb begin
		cfg_rd = CFG_ZERO_WORD;
		case ({addr_q[7:2], 2'b00})
			CFG_COMMAND: cfg_rd = {30'h0000_0000, mem_en_q, 1'b0};
			CFG_MEM_BASE: cfg_rd = {base_q, 12'h000};
			CFG_SUBSYS: cfg_rd = subsys_q;
			CFG_EXP_ROM: cfg_rd = CFG_ZERO_WORD;
			CFG_RSVD_A: cfg_rd = CFG_ZERO_WORD;
			CFG_RSVD_B: cfg_rd = CFG_ZERO_WORD;
			CFG_INT_ROUTE: cfg_rd = {MAX_LAT_VALUE, MIN_GNT_VALUE, INT_PIN_VALUE, int_line_q};
			default: cfg_rd = CFG_ZERO_WORD;
		endcase
	end

	assign rx_lanes = I_RX_DATA << lane_shift(be_q);
	// data low, status high per pair
	always_comb begin
		stat_word = 32'h0000_0000;
		case (be_q)
			4'b0011: stat_word = {16'h0000, I_RX_STATUS[7:0], I_RX_DATA[7:0]};
			4'b1100: stat_word = {I_RX_STATUS[7:0], I_RX_DATA[7:0], 16'h0000};
			4'b1111: stat_word = {I_RX_STATUS[15:8], I_RX_DATA[15:8], I_RX_STATUS[7:0], I_RX_DATA[7:0]};
			default: stat_word = 32'h0000_0000;
		endcase
	end

	// Read data picked in the cycle before the data phase, so it lands in O_AD together with TRDY
	always_comb begin
		rdata_d = 32'h0000_0000;
		if (state_q == ST_EXEC && !is_wr_q) begin
			if (is_cfg_q) begin
				rdata_d = cfg_rd;
			end else if (rg_fifo) begin
				rdata_d = rx_lanes;
			end else if (rg_stat && stat_ok) begin
				rdata_d = stat_word;
			end else begin
				rdata_d = 32'h0000_0000;
			end
		end else if (state_q == ST_RDATA) begin
			rdata_d = I_REG_RDATA;
		end
	end

	// Requests toward channel registers and FIFOs
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			O_REG_REQ <= 1'b0;
			O_REG_WR <= 1'b0;
			O_REG_DEVCFG <= 1'b0;
			O_REG_CH <= '0;
			O_REG_OFFSET <= 9'h000;
			O_REG_BE <= 4'h0;
			O_REG_WDATA <= 32'h0000_0000;
			O_RX_POP <= 1'b0;
			O_RX_CH <= '0;
			O_RX_COUNT <= 3'h0;
		end else begin
			O_REG_REQ <= 1'b0;
			O_RX_POP <= 1'b0;
			if (state_q == ST_EXEC && !is_cfg_q) begin
				if (rg_uart || rg_devcfg) begin
					O_REG_REQ <= 1'b1;
					O_REG_WR <= is_wr_q;
					O_REG_DEVCFG <= rg_devcfg;
					O_REG_CH <= blk_ch;
					O_REG_OFFSET <= {blk_dw, 2'b00};
					O_REG_BE <= be_q;
					O_REG_WDATA <= wdata_q;
				end
				if (!is_wr_q && rg_fifo && be_q != 4'h0) begin
					O_RX_POP <= 1'b1;
					O_RX_CH <= blk_ch;
					O_RX_COUNT <= lane_count(be_q);
				end
				if (!is_wr_q && rg_stat && stat_ok) begin
					O_RX_POP <= 1'b1;
					O_RX_CH <= blk_ch;
					O_RX_COUNT <= (be_q == 4'b1111) ? 3'd2 : 3'd1;
				end
			end
		end
	end

	assign tx_push = (state_q == ST_EXEC) && !is_cfg_q && is_wr_q && rg_fifo && (be_q != 4'h0);

	// A full buffer holds the data phase open instead of dropping the word
	pumd_skid_buffer #(
		.WIDTH(TXE_W),
		.DEPTH(TX_BUF_DEPTH)
	) u_tx_buf (
		.i_clock(I_CLOCK),
		.i_reset_n(I_RESET_N),
		.i_valid(tx_push),
		.o_ready(tx_ready),
		.i_data({blk_ch, lane_count(be_q), wdata_q >> lane_shift(be_q)}),
		.o_valid(O_TX_VALID),
		.i_ready(I_TX_READY),
		.o_data({O_TX_CH, O_TX_COUNT, O_TX_DATA})
	);

	// Bus outputs registered from the next state
	always_ff @(posedge I_CLOCK) begin
		if (!I_RESET_N) begin
			O_TRDY_N <= 1'b1;
			O_STOP_N <= 1'b1;
			O_DEVSEL_N <= 1'b1;
			O_CTL_OE_N <= 1'b1;
			O_AD_OE_N <= 1'b1;
			O_AD <= 32'h0000_0000;
		end else begin
			// Single data phase per claim: disconnect with the data
			O_TRDY_N <= (state_d != ST_XFER);
			O_STOP_N <= (state_d != ST_XFER);
			O_DEVSEL_N <= !(state_d == ST_WAIT_IRDY || state_d == ST_EXEC
				|| state_d == ST_RDATA || state_d == ST_XFER);
			O_CTL_OE_N <= (state_d == ST_IDLE);
			O_AD_OE_N <= !(state_d == ST_XFER && !is_wr_q);
			O_AD <= (state_d == ST_XFER && !is_wr_q) ? rdata_d : 32'h0000_0000;
		end
	end
endmodule // pumd_decoder
`default_nettype wire

// file: core/pumd_pkg.sv
// Shared constants for the PCI memory-window decoder of the octal UART
package pumd_pkg;
	// PCI bus commands on C/BE during the address phase
	localparam logic [3:0] CMD_MEM_RD = 4'h6;
	localparam logic [3:0] CMD_MEM_WR = 4'h7;
	localparam logic [3:0] CMD_CFG_RD = 4'ha;
	localparam logic [3:0] CMD_CFG_WR = 4'hb;
	// Configuration dword byte offsets
	localparam logic [7:0] CFG_COMMAND = 8'h04;
	localparam logic [7:0] CFG_MEM_BASE = 8'h10;
	localparam logic [7:0] CFG_SUBSYS = 8'h2c;
	localparam logic [7:0] CFG_EXP_ROM = 8'h30;
	localparam logic [7:0] CFG_RSVD_A = 8'h34;
	localparam logic [7:0] CFG_RSVD_B = 8'h38;
	localparam logic [7:0] CFG_INT_ROUTE = 8'h3c;
	// Field positions and fixed values
	localparam int CMD_MEM_EN_BIT = 1;
	localparam int BASE_LSB = 12;
	localparam int BASE_W = 20;
	localparam logic [7:0] INT_PIN_VALUE = 8'h01;
	localparam logic [7:0] MAX_LAT_VALUE = 8'h00;
	localparam logic [7:0] MIN_GNT_VALUE = 8'h00;
	localparam logic [31:0] CFG_ZERO_WORD = 32'h0000_0000;
	localparam logic [31:0] SUBSYS_RST = 32'h0000_0000;
	localparam logic [7:0] INT_LINE_RST = 8'h00;
	localparam logic [BASE_W-1:0] BASE_RST = 20'h0_0000;
	// Window layout: 4K window, 8 blocks of 512 bytes
	localparam int WINDOW_BYTES = 4096;
	localparam int CHANNELS = 8;
	localparam int BLOCK_BYTES = 512;
	localparam int CH_W = 3;
	// Dword indices within a block
	localparam logic [6:0] DW_DEVCFG_LO = 7'h20;
	localparam logic [6:0] DW_DEVCFG_HI = 7'h24;
	localparam logic [4:0] DW_UART_TAG = 5'h00;
	localparam logic [2:0] DW_FIFO_TAG = 3'h4;
	localparam logic [1:0] DW_STAT_TAG = 2'h3;
	localparam int FIFO_BYTES = 64;
	// Pin synchroniser: {frame_n, irdy_n, idsel, cbe_n[3:0], ad[31:0]}
	localparam int PIN_W = 39;
	localparam logic [PIN_W-1:0] PIN_RST = 39'h60_0000_0000;
	// Transmit buffer entry: {channel, byte count, data}
	localparam int TXE_W = 38;
	localparam int TX_DEPTH = 2;
endpackage : pumd_pkg

// file: core/pumd_skid_buffer.sv
// Small valid/ready buffer for transmit words bound for the channel FIFOs
`timescale 1ns/1ps
`default_nettype none
module pumd_skid_buffer #(
	parameter int WIDTH = 38,
	parameter int DEPTH = 2
) (
	input wire logic i_clock,
	input wire logic i_reset_n,
	input wire logic i_valid,
	output logic o_ready,
	input wire logic [WIDTH-1:0] i_data,
	output logic o_valid,
	input wire logic i_ready,
	output logic [WIDTH-1:0] o_data
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	// Sized to the fill counter: a PW-bit cast would wrap DEPTH to zero and never signal ready
	localparam logic [PW:0] DEPTH_C = DEPTH[PW:0];

	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [PW-1:0] wr_ptr_q;
	logic [PW-1:0] rd_ptr_q;
	logic [PW:0] fill_q;
	logic push;
	logic pop;

	assign o_ready = (fill_q != DEPTH_C);
	assign o_valid = (fill_q != '0);
	assign o_data = mem_q[rd_ptr_q];
	assign push = i_valid && o_ready;
	assign pop = o_valid && i_ready;

	always_ff @(posedge i_clock) begin
		if (push) begin
			mem_q[wr_ptr_q] <= i_data;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_reset_n) begin
			wr_ptr_q <= '0;
			rd_ptr_q <= '0;
			fill_q <= '0;
		end else begin
			if (push) begin
				wr_ptr_q <= (wr_ptr_q == PW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
			end
			if (pop) begin
				rd_ptr_q <= (rd_ptr_q == PW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;
			end
			if (push && !pop) begin
				fill_q <= fill_q + 1'b1;
			end else if (pop && !push) begin
				fill_q <= fill_q - 1'b1;
			end
		end
	end
endmodule // pumd_skid_buffer
`default_nettype wire

// file: verification/pumd_chan_model.sv
// Channel-side model: UART register file, receive byte source, stallable transmit sink
`timescale 1ns/1ps
`default_nettype none
module pumd_chan_model (
	input wire logic i_clock,
	input wire logic i_stall,
	input wire logic i_reg_req,
	input wire logic i_reg_wr,
	input wire logic i_reg_devcfg,
	input wire logic [2:0] i_reg_ch,
	input wire logic [8:0] i_reg_offset,
	input wire logic [3:0] i_reg_be,
	input wire logic [31:0] i_reg_wdata,
	output logic [31:0] o_reg_rdata,
	input wire logic i_rx_pop,
	input wire logic [2:0] i_rx_count,
	output logic [31:0] o_rx_data,
	output logic [31:0] o_rx_status,
	input wire logic i_tx_valid,
	output logic o_tx_ready,
	input wire logic [37:0] i_tx_word
);
	logic [31:0] regs_q [0:127];
	logic [7:0] rx_ptr_q = 8'h00;
	logic [37:0] tx_seen [$];
	wire logic [6:0] idx = {i_reg_devcfg, i_reg_ch, i_reg_offset[4:2]};
	initial begin
		for (int i = 0; i < 128; i++) begin
			regs_q[i] = 32'h0;
		end
	end
	assign o_reg_rdata = regs_q[idx];
	assign o_tx_ready = !i_stall;
	// Byte n of the receive stream is n, its status byte n xor a5
	always_comb begin
		for (int b = 0; b < 4; b++) begin
			o_rx_data[8*b +: 8] = rx_ptr_q + 8'(b);
			o_rx_status[8*b +: 8] = (rx_ptr_q + 8'(b)) ^ 8'ha5;
		end
	end
	always @(posedge i_clock) begin
		if (i_reg_req && i_reg_wr) begin
			for (int b = 0; b < 4; b++) begin
				if (i_reg_be[b]) begin
					regs_q[idx][8*b +: 8] <= i_reg_wdata[8*b +: 8];
				end
			end
		end
		if (i_rx_pop) begin
			rx_ptr_q <= rx_ptr_q + 8'(i_rx_count);
		end
		if (i_tx_valid && o_tx_ready) begin
			tx_seen.push_back(i_tx_word);
		end
	end
endmodule // pumd_chan_model
`default_nettype wire

// file: verification/pumd_decoder_sva.sv
// Checker for the bus and channel-side ports of the window decoder
`timescale 1ns/1ps
`default_nettype none
module pumd_decoder_sva (
	input wire logic I_CLOCK,
	input wire logic I_RESET_N,
	input wire logic [31:0] O_AD,
	input wire logic O_AD_OE_N,
	input wire logic O_TRDY_N,
	input wire logic O_DEVSEL_N,
	input wire logic O_STOP_N,
	input wire logic O_CTL_OE_N,
	input wire logic O_REG_REQ,
	input wire logic O_REG_WR,
	input wire logic O_REG_DEVCFG,
	input wire logic [2:0] O_REG_CH,
	input wire logic [8:0] O_REG_OFFSET,
	input wire logic [3:0] O_REG_BE,
	input wire logic [31:0] I_REG_RDATA,
	input wire logic O_RX_POP,
	input wire logic [2:0] O_RX_COUNT,
	input wire logic O_TX_VALID,
	input wire logic I_TX_READY,
	input wire logic [2:0] O_TX_CH,
	input wire logic [31:0] O_TX_DATA
);
	default clocking cb @(posedge I_CLOCK); endclocking
	default disable iff (!I_RESET_N);
	property p_stop_with_trdy;
		!O_TRDY_N |-> !O_STOP_N && !O_DEVSEL_N && !O_CTL_OE_N;
	endproperty
	a_stop_with_trdy: assert property (p_stop_with_trdy) else $error("trdy without stop or devsel");
	property p_single_phase;
		!O_TRDY_N |=> O_TRDY_N [*3];
	endproperty
	a_single_phase: assert property (p_single_phase) else $error("trdy held past one phase");
	property p_uart_offset;
		O_REG_REQ && !O_REG_DEVCFG |-> O_REG_OFFSET < 9'h010 && O_REG_OFFSET[1:0] == 2'h0 && O_REG_BE != 4'h0;
	endproperty
	a_uart_offset: assert property (p_uart_offset) else $error("uart register offset out of range");
	property p_devcfg;
		O_REG_REQ && O_REG_DEVCFG |-> O_REG_CH == 3'h0 && O_REG_OFFSET inside {[9'h080:9'h090]};
	endproperty
	a_devcfg: assert property (p_devcfg) else $error("shared register access off channel 0");
	property p_reg_read;
		O_REG_REQ && !O_REG_WR && O_REG_BE == 4'hf |-> ##1 !O_TRDY_N && !O_AD_OE_N && O_AD == $past(I_REG_RDATA);
	endproperty
	a_reg_read: assert property (p_reg_read) else $error("register read data not returned");
	property p_pop_answer;
		O_RX_POP |-> O_RX_COUNT inside {[3'h1:3'h4]} ##[0:4] (!O_TRDY_N && !O_AD_OE_N);
	endproperty
	a_pop_answer: assert property (p_pop_answer) else $error("receive pop without read answer");
	property p_tx_hold;
		O_TX_VALID && !I_TX_READY |=> O_TX_VALID && $stable(O_TX_DATA) && $stable(O_TX_CH);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("transmit word dropped while stalled");
	property p_claimed_only;
		O_REG_REQ || O_RX_POP |-> !O_DEVSEL_N;
	endproperty
	a_claimed_only: assert property (p_claimed_only) else $error("channel access outside a claim");
endmodule // pumd_decoder_sva
bind pumd_decoder pumd_decoder_sva i_sva (.*);
`default_nettype wire

// file: verification/test_pumd_decoder.sv
// Self-checking bench: PCI configuration and memory cycles against the window decoder
`timescale 1ns/1ps
`default_nettype none
module test_pumd_decoder;
	import pumd_pkg::*;
	logic I_CLOCK = 1'b0;
	logic I_RESET_N = 1'b0;
	logic I_FRAME_N = 1'b1;
	logic I_IRDY_N = 1'b1;
	logic I_IDSEL = 1'b0;
	logic [3:0] I_CBE_N = 4'hf;
	logic [31:0] I_AD = 32'h0;
	logic I_EE_LOAD = 1'b0;
	logic [31:0] I_EE_SUBSYS = 32'h0;
	logic stall = 1'b0;
	logic O_AD_OE_N, O_TRDY_N, O_DEVSEL_N, O_STOP_N, O_CTL_OE_N, O_REG_REQ, O_REG_WR, O_REG_DEVCFG;
	logic O_RX_POP, O_TX_VALID, I_TX_READY, hit;
	logic [2:0] O_REG_CH, O_RX_CH, O_RX_COUNT, O_TX_CH, O_TX_COUNT;
	logic [8:0] O_REG_OFFSET;
	logic [3:0] O_REG_BE, be;
	logic [31:0] O_AD, O_REG_WDATA, I_REG_RDATA, I_RX_DATA, I_RX_STATUS, O_TX_DATA, rd, exp, m;
	logic [31:0] base = 32'h1234_5000;
	logic [7:0] rp = 8'h00;
	int n_mismatch = 0;
	int total_checks = 0;
	always #2 I_CLOCK = ~I_CLOCK;
	pumd_decoder i_dut (.*);
	pumd_chan_model i_chan (.i_clock(I_CLOCK), .i_stall(stall), .i_reg_req(O_REG_REQ), .i_reg_wr(O_REG_WR),
		.i_reg_devcfg(O_REG_DEVCFG), .i_reg_ch(O_REG_CH), .i_reg_offset(O_REG_OFFSET), .i_reg_be(O_REG_BE),
		.i_reg_wdata(O_REG_WDATA), .o_reg_rdata(I_REG_RDATA), .i_rx_pop(O_RX_POP), .i_rx_count(O_RX_COUNT),
		.o_rx_data(I_RX_DATA), .o_rx_status(I_RX_STATUS), .i_tx_valid(O_TX_VALID), .o_tx_ready(I_TX_READY),
		.i_tx_word({O_TX_CH, O_TX_COUNT, O_TX_DATA}));
	task automatic check(input string what, input logic [63:0] want, input logic [63:0] got);
		total_checks++;
		if (got !== want) begin
			n_mismatch++;
			$display("unexpected %s: expected %h, seen %h", what, want, got);
		end
	endtask
	// One single-phase transaction; hit tells whether TRDY came within the limit
	task automatic bus(input logic [3:0] cmd, input logic [31:0] addr, input logic [3:0] ben,
		input logic [31:0] wd, output logic [31:0] rdo, output logic ok);
		ok = 1'b0;
		rdo = 32'h0;
		I_IDSEL = (cmd == CMD_CFG_RD) || (cmd == CMD_CFG_WR);
		I_FRAME_N = 1'b0;
		I_CBE_N = cmd;
		I_AD = addr;
		@(posedge I_CLOCK);
		#1;
		I_FRAME_N = 1'b1;
		I_IRDY_N = 1'b0;
		I_CBE_N = ~ben;
		I_AD = wd;
		repeat (60) begin
			@(posedge I_CLOCK);
			if (O_TRDY_N === 1'b0) begin
				ok = 1'b1;
				rdo = O_AD;
				break;
			end
		end
		#1;
		I_IRDY_N = 1'b1;
		I_IDSEL = 1'b0;
		I_CBE_N = 4'hf;
		I_AD = 32'h0;
		repeat (20) begin
			@(posedge I_CLOCK);
			if (O_CTL_OE_N === 1'b1) break;
		end
		#1;
	endtask
	task automatic tally_and_finish();
		$display("checks %0d, mismatches %0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	initial begin
		repeat (20000) @(posedge I_CLOCK);
		n_mismatch++;
		$display("unexpected run length: expected end of tests, seen watchdog expiry");
		tally_and_finish();
	end
	initial begin
		repeat (16) @(posedge I_CLOCK);
		#1;
		I_RESET_N = 1'b1;
		repeat (4) @(posedge I_CLOCK);
		#1;
		bus(CMD_MEM_RD, 32'h0, 4'hf, 32'h0, rd, hit);
		check("claim while disabled", 64'h0, 64'(hit));
		for (int i = 0; i < 5; i++) begin
			bus(CMD_CFG_WR, 32'(8'h2c + 4 * i), 4'hf, 32'hffff_ffff, rd, hit);
			bus(CMD_CFG_RD, 32'(8'h2c + 4 * i), 4'hf, 32'h0, rd, hit);
			check("config word", (i == 4) ? 64'h1ff : 64'h0, 64'(rd));
		end
		// Arbitrary identifiers for the loader
		I_EE_SUBSYS = 32'h5a5a_0c3c;
		I_EE_LOAD = 1'b1;
		@(posedge I_CLOCK);
		#1;
		I_EE_LOAD = 1'b0;
		bus(CMD_CFG_RD, 32'h2c, 4'hf, 32'h0, rd, hit);
		check("subsystem word", 64'h5a5a_0c3c, 64'(rd));
		bus(CMD_CFG_WR, 32'h3c, 4'h1, 32'h0000_005a, rd, hit);
		bus(CMD_CFG_RD, 32'h3c, 4'hf, 32'h0, rd, hit);
		check("interrupt routing", 64'h15a, 64'(rd));
		bus(CMD_CFG_WR, 32'h10, 4'hf, 32'hffff_ffff, rd, hit);
		bus(CMD_CFG_RD, 32'h10, 4'hf, 32'h0, rd, hit);
		check("base register", 64'hffff_f000, 64'(rd));
		bus(CMD_CFG_WR, 32'h10, 4'hf, base, rd, hit);
		bus(CMD_CFG_WR, 32'h04, 4'hf, 32'h2, rd, hit);
		bus(CMD_MEM_RD, base + 32'h1000, 4'hf, 32'h0, rd, hit);
		check("claim above window", 64'h0, 64'(hit));
		bus(CMD_MEM_RD, base - 32'h4, 4'hf, 32'h0, rd, hit);
		check("claim below window", 64'h0, 64'(hit));
		// All writes first so that channel aliasing shows on readback
		for (int c = 0; c < CHANNELS; c++) begin
			bus(CMD_MEM_WR, base + 32'(c * BLOCK_BYTES + 8), 4'hf, 32'(32'h1100_0000 + c), rd, hit);
		end
		for (int c = 0; c < CHANNELS; c++) begin
			bus(CMD_MEM_RD, base + 32'(c * BLOCK_BYTES + 8), 4'hf, 32'h0, rd, hit);
			check("uart register", 64'(32'h1100_0000 + c), 64'(rd));
		end
		bus(CMD_MEM_WR, base + 32'h84, 4'hf, 32'h4433_2211, rd, hit);
		bus(CMD_MEM_WR, base + 32'h84, 4'h4, 32'h00ee_0000, rd, hit);
		bus(CMD_MEM_RD, base + 32'h84, 4'hf, 32'h0, rd, hit);
		check("shared register byte", 64'h44ee_2211, 64'(rd));
		bus(CMD_MEM_WR, base + 32'h90, 4'he, 32'ha1b2_c3d4, rd, hit);
		bus(CMD_MEM_RD, base + 32'h90, 4'hf, 32'h0, rd, hit);
		check("shared register 24-bit", 64'ha1b2_c300, 64'(rd));
		foreach (m[i]) begin
			if (i < 3) begin
				exp = (i == 0) ? 32'h240 : (i == 1) ? 32'h2a0 : 32'h350;
				bus(CMD_MEM_WR, base + exp, 4'hf, 32'hffff_ffff, rd, hit);
				bus(CMD_MEM_RD, base + exp, 4'hf, 32'h0, rd, hit);
				check("reserved word", 64'h0, 64'(rd));
			end
		end
		for (int i = 0; i < 4; i++) begin
			be = 4'((1 << (i + 1)) - 1);
			bus(CMD_MEM_RD, base + 32'h500, be, 32'h0, rd, hit);
			for (int b = 0; b < 4; b++) begin
				m[8*b +: 8] = {8{be[b]}};
				exp[8*b +: 8] = rp + 8'(b);
			end
			check("rx data", 64'(exp & m), 64'(rd & m));
			rp += 8'(i + 1);
		end
		bus(CMD_MEM_RD, base + 32'h580, 4'h3, 32'h0, rd, hit);
		check("status pair", 64'({rp ^ 8'ha5, rp}), 64'(rd & 32'hffff));
		rp += 8'h1;
		bus(CMD_MEM_RD, base + 32'h580, 4'hf, 32'h0, rd, hit);
		check("status pairs", 64'({(rp + 8'h1) ^ 8'ha5, rp + 8'h1, rp ^ 8'ha5, rp}), 64'(rd));
		rp += 8'h2;
		bus(CMD_MEM_RD, base + 32'h580, 4'h1, 32'h0, rd, hit);
		check("status byte read", 64'h0, 64'(rd));
		bus(CMD_MEM_RD, base + 32'h500, 4'h1, 32'h0, rd, hit);
		check("rx after refusal", 64'(rp), 64'(rd & 32'hff));
		check("rx channel", 64'h2, 64'(O_RX_CH));
		stall = 1'b1;
		fork
			begin
				bus(CMD_MEM_WR, base + 32'h700, 4'h1, 32'h0000_00c1, rd, hit);
				bus(CMD_MEM_WR, base + 32'h700, 4'h3, 32'h0000_c3c2, rd, hit);
				bus(CMD_MEM_WR, base + 32'h700, 4'hf, 32'hc7c6_c5c4, rd, hit);
				check("write while full", 64'h1, 64'(hit));
				bus(CMD_MEM_WR, base + 32'h700, 4'hc, 32'hc9c8_0000, rd, hit);
			end
			begin
				repeat (50) @(posedge I_CLOCK);
				check("words through stall", 64'h0, 64'(i_chan.tx_seen.size()));
				#1;
				stall = 1'b0;
			end
		join
		repeat (8) @(posedge I_CLOCK);
		check("tx word count", 64'h4, 64'(i_chan.tx_seen.size()));
		check("tx word 0", 64'({3'h3, 3'h1, 32'h0000_00c1}), 64'(i_chan.tx_seen[0]));
		check("tx word 1", 64'({3'h3, 3'h2, 32'h0000_c3c2}), 64'(i_chan.tx_seen[1]));
		check("tx word 2", 64'({3'h3, 3'h4, 32'hc7c6_c5c4}), 64'(i_chan.tx_seen[2]));
		check("tx word 3", 64'({3'h3, 3'h2, 32'h0000_c9c8}), 64'(i_chan.tx_seen[3]));
		tally_and_finish();
	end
endmodule // test_pumd_decoder
`default_nettype wire
